/* verilog/time_mgmt_consts.svh */
// constants of the time management status and control registers
// assumes a 5-bit word address and a 16-bit data bus
`ifndef TIME_MGMT_CONSTS_SVH
`define TIME_MGMT_CONSTS_SVH

`define TM_DATA_W      16
`define TM_ADDR_W      5
`define TM_CTRL_ADDR   5'h1b
`define TM_MSTAT_ADDR  5'h1a

`define TM_CB_TVLD     9
`define TM_CB_RUN      8
`define TM_CB_SEL      7
`define TM_CB_EVT      6
`define TM_CB_EXT      5
`define TM_CB_WAVE     4

`define TM_MS_TOGGLE   15
`define TM_MS_PULSE    14
`define TM_MS_WAVE     13
`define TM_MS_INIT     12

`define TM_CTRL_RST    16'h0000
`define TM_MSTAT_RST   16'h0000
`define TM_RD_IDLE     16'h0000

`endif

/* verilog/time_mgmt_pkg.sv */
// types shared by the time management register block
// assumes the constants header is included by each user
package time_mgmt_pkg;

	typedef enum logic [1:0] {
		RES_OK       = 2'h0,
		RES_MSG_ERR  = 2'h1,
		RES_SYNC_ERR = 2'h2,
		RES_FORCED   = 2'h3
	} result_t;

	typedef enum logic [1:0] {
		OP_SERIAL     = 2'h0,
		OP_PARALLEL   = 2'h1,
		OP_STANDALONE = 2'h2
	} op_mode_t;

	// gray steps only on idle -> read, write -> done and done -> idle
	typedef enum logic [1:0] {
		BUS_IDLE  = 2'h0,
		BUS_READ  = 2'h1,
		BUS_WRITE = 2'h3,
		BUS_DONE  = 2'h2
	} bus_state_t;

	typedef struct packed {
		logic       pulse;
		logic       wave;
		logic       init;
		logic [3:0] chain;
		logic [7:0] mission;
	} msg_flags_t;

endpackage

/* verilog/sync_msg_if.sv */
// carries message, marker and verdict signals between the register top
// and its capture and judging submodules; single clock domain
`timescale 1ns/1ps
interface sync_msg_if;
	import time_mgmt_pkg::*;

	logic       msg_valid;
	msg_flags_t msg_flags;
	logic       marker;
	logic       msg_err;
	logic       marker_to;
	logic       mismatch;
	logic       warn;
	logic       go_reached;
	logic       ext_err;
	op_mode_t   op_mode;
	logic       pend_init;
	logic [15:0] status_word;
	result_t    code;
	logic       sync_go;

	modport top (output msg_valid, msg_flags, marker, msg_err, marker_to, mismatch,
		warn, go_reached, ext_err, op_mode, input status_word, code, sync_go);
	modport cap (input msg_valid, msg_flags, marker, output pend_init, status_word);
	modport judge (input marker, msg_err, marker_to, mismatch, warn, go_reached,
		ext_err, op_mode, pend_init, output code, sync_go);
endinterface

/* verilog/msg_status_capture.sv */
// holds the flags of the last valid message and loads them into the
// message status word at each synchronisation marker that a new valid message preceded
// assumes msg_valid only pulses for messages that passed their checks
`timescale 1ns/1ps
`include "time_mgmt_consts.svh"
module msg_status_capture
	import time_mgmt_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// message side
	sync_msg_if.cap   sm
);

	msg_flags_t  pend_r;
	logic        pend_vld_r;
	logic [15:0] stat_r;
	wire         load_now = sm.marker & pend_vld_r;

	// a message in the marker's own cycle counts for the next marker
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pend_r     <= '0;
			pend_vld_r <= 1'b0;
		end else begin
			if (sm.msg_valid)
				pend_r <= sm.msg_flags;
			pend_vld_r <= sm.msg_valid | (pend_vld_r & ~sm.marker);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			stat_r <= `TM_MSTAT_RST;
		else if (load_now)
			stat_r <= {~stat_r[`TM_MS_TOGGLE], pend_r};
	end

	assign sm.status_word = stat_r;
	assign sm.pend_init   = pend_vld_r & pend_r.init;
endmodule

/* verilog/sync_judge.sv */
// decides at each synchronisation marker whether the local time is
// synchronised and which handling result code is reported
// assumes the checking inputs are valid in the marker cycle
`timescale 1ns/1ps
`include "time_mgmt_consts.svh"
module sync_judge
	import time_mgmt_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// message side
	sync_msg_if.judge sm
);

	result_t code_r;
	logic    go_r;
	result_t code_nxt;
	logic    go_nxt;
	wire     alone = (sm.op_mode == OP_STANDALONE);
	wire     forced = sm.pend_init | (~alone & sm.go_reached & ~sm.ext_err);

	// an external error blocks synchronisation before any forcing applies
	always_comb begin
		code_nxt = code_r;
		go_nxt   = 1'b0;
		if (sm.marker) begin
			if (sm.msg_err | (sm.marker_to & ~alone)) begin
				code_nxt = RES_MSG_ERR;
			end else if (sm.ext_err) begin
				code_nxt = RES_SYNC_ERR;
			end else if (sm.mismatch & forced) begin
				code_nxt = RES_FORCED;
				go_nxt   = 1'b1;
			end else if (sm.mismatch) begin
				code_nxt = RES_SYNC_ERR;
			end else if (alone & sm.warn) begin
				code_nxt = RES_SYNC_ERR;
				go_nxt   = 1'b1;
			end else begin
				code_nxt = RES_OK;
				go_nxt   = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			code_r <= RES_OK;
			go_r   <= 1'b0;
		end else begin
			code_r <= code_nxt;
			go_r   <= go_nxt;
		end
	end

	assign sm.code    = code_r;
	assign sm.sync_go = go_r;
endmodule

/* verilog/time_mgmt_regs.sv */
// status and control registers of the local time management unit,
// reached over the parallel microprocessor pins
// assumes bus control pins are synchronous to clk_sys and held low
// for the whole access; other registers of the unit live elsewhere
`timescale 1ns/1ps
`include "time_mgmt_consts.svh"
module time_mgmt_regs
	import time_mgmt_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_b,
	// parallel microprocessor interface
	input  wire logic                  cs_b,
	input  wire logic                  rd_b,
	input  wire logic                  wr_b,
	input  wire logic [`TM_ADDR_W-1:0] addr,
	input  wire logic [`TM_DATA_W-1:0] data_in,
	output logic      [`TM_DATA_W-1:0] data_out,
	output logic                       data_oe,
	output logic                       ready_b,
	input  wire logic                  mproc,
	// message reception engine
	input  wire logic                  msg_valid,
	input  wire logic                  msg_pulse,
	input  wire logic                  msg_wave,
	input  wire logic                  msg_init,
	input  wire logic [3:0]            msg_chain,
	input  wire logic [7:0]            msg_mission,
	input  wire logic                  marker,
	input  wire logic                  msg_err,
	input  wire logic                  marker_to,
	input  wire logic                  mismatch,
	input  wire logic                  warn,
	input  wire logic                  go_reached,
	input  wire logic [1:0]            op_mode,
	// device pins mirrored in the control register or merged into sw_event and ext_error
	input  wire logic                  tvld,
	input  wire logic                  pfgwave,
	input  wire logic                  swstart,
	input  wire logic                  swevent,
	input  wire logic                  exterin,
	// results towards the timing engines
	output logic [1:0]                 result_code,
	output logic                       sync_go,
	output logic                       sw_run,
	output logic                       sw_event,
	output logic                       ext_error
);

	sync_msg_if sm ();

	// bus access state
	bus_state_t           state_r;
	bus_state_t           state_nxt;
	logic                 rd_cyc_r;
	logic                 rd_cyc_nxt;
	logic [`TM_DATA_W-1:0] dout_r;
	logic [`TM_DATA_W-1:0] dout_nxt;

	// control register state
	logic sel_r;
	logic sel_nxt;
	logic run_r;
	logic run_nxt;
	logic evt_r;
	logic evt_nxt;
	logic evt_pulse_nxt;
	logic extbit_r;
	logic extbit_nxt;
	logic tvld_r;
	logic wave_r;
	logic sw_event_r;
	logic ext_err_r;

	// access decode
	wire rd_req   = ~cs_b & ~rd_b;
	wire wr_req   = ~cs_b & ~wr_b;
	wire released = cs_b | (rd_b & wr_b);
	wire hit_ctrl = (addr == `TM_CTRL_ADDR);
	wire hit_stat = (addr == `TM_MSTAT_ADDR);
	wire in_idle  = (state_r == BUS_IDLE);
	wire in_done  = (state_r == BUS_DONE);
	// a read wins when a faulty host lowers both strobes together
	wire start_rd = in_idle & rd_req;
	wire start_wr = in_idle & ~rd_req & wr_req;
	wire wr_ctrl  = start_wr & hit_ctrl;

	// written fields
	wire w_run = data_in[`TM_CB_RUN];
	wire w_sel = data_in[`TM_CB_SEL];
	wire w_evt = data_in[`TM_CB_EVT];
	wire w_ext = data_in[`TM_CB_EXT];
	wire sel_move = wr_ctrl & ~w_run;
	wire evt_rise = wr_ctrl & w_evt & ~evt_r;

	// read image of the control register; low nibble belongs elsewhere
	wire [`TM_DATA_W-1:0] ctrl_image = {
		6'h00,
		tvld_r,
		run_r,
		sel_r,
		evt_r,
		extbit_r,
		wave_r,
		4'h0
	};

	// unmapped addresses read as zero so the data pins never carry stale words
	wire [`TM_DATA_W-1:0] rd_mux =
		hit_ctrl ? ctrl_image :
		hit_stat ? sm.status_word :
		`TM_RD_IDLE;

	// bus sequencing: one access taken per assertion of the strobes
	always_comb begin
		state_nxt  = state_r;
		rd_cyc_nxt = rd_cyc_r;
		dout_nxt   = dout_r;
		case (state_r)
			BUS_IDLE: begin
				if (start_rd) begin
					state_nxt  = BUS_READ;
					rd_cyc_nxt = 1'b1;
					dout_nxt   = rd_mux;
				end else if (start_wr) begin
					state_nxt  = BUS_WRITE;
					rd_cyc_nxt = 1'b0;
				end
			end
			BUS_READ: begin
				state_nxt = BUS_DONE;
			end
			BUS_WRITE: begin
				state_nxt = BUS_DONE;
			end
			BUS_DONE: begin
				if (released) begin
					state_nxt  = BUS_IDLE;
					rd_cyc_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt  = BUS_IDLE;
				rd_cyc_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			state_r <= BUS_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			rd_cyc_r <= 1'b0;
		else
			rd_cyc_r <= rd_cyc_nxt;
	end

	// read data is frozen at the take so a slow host sees one stable word
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			dout_r <= `TM_RD_IDLE;
		else
			dout_r <= dout_nxt;
	end

	// select may only move when the same write clears the run bit
	always_comb begin
		sel_nxt = sel_r;
		if (sel_move)
			sel_nxt = w_sel;
	end

	// run bit: software value under register control, pin copy otherwise;
	// the pin copy lags swstart by one clock like the other mirrored bits
	always_comb begin
		run_nxt = run_r;
		if (!sel_nxt)
			run_nxt = swstart;
		else if (wr_ctrl)
			run_nxt = w_run;
	end

	// event bit only ever changes by a write, so pin pulses never show
	always_comb begin
		evt_nxt       = wr_ctrl ? w_evt : evt_r;
		evt_pulse_nxt = evt_rise;
	end

	always_comb begin
		extbit_nxt = wr_ctrl ? w_ext : extbit_r;
	end

	// read-only positions take no write data, only the device's own copies
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			sel_r <= 1'b0;
		else
			sel_r <= sel_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			run_r <= 1'b0;
		else
			run_r <= run_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			evt_r <= 1'b0;
		else
			evt_r <= evt_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			extbit_r <= 1'b0;
		else
			extbit_r <= extbit_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			tvld_r <= 1'b0;
		else
			tvld_r <= tvld;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			wave_r <= 1'b0;
		else
			wave_r <= pfgwave;
	end

	// the stopwatch sees register and pin events on one line
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			sw_event_r <= 1'b0;
		else
			sw_event_r <= evt_pulse_nxt | swevent;
	end

	// one register stage on the error path: a pin raised in the marker
	// cycle itself is only seen by the next marker
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			ext_err_r <= 1'b0;
		else
			ext_err_r <= extbit_nxt | exterin;
	end

	// message side of the shared interface
	assign sm.msg_valid         = msg_valid;
	assign sm.msg_flags.pulse   = msg_pulse;
	assign sm.msg_flags.wave    = msg_wave;
	assign sm.msg_flags.init    = msg_init;
	assign sm.msg_flags.chain   = msg_chain;
	assign sm.msg_flags.mission = msg_mission;
	assign sm.marker            = marker;
	assign sm.msg_err           = msg_err;
	assign sm.marker_to         = marker_to;
	assign sm.mismatch          = mismatch;
	assign sm.warn              = warn;
	assign sm.go_reached        = go_reached;
	assign sm.ext_err           = ext_err_r;
	assign sm.op_mode           = op_mode_t'(op_mode);

	// status reloads only at markers that a valid message preceded
	msg_status_capture u_capture (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.sm      (sm.cap)
	);

	// code and sync_go come out one clock after the marker
	sync_judge u_judge (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.sm      (sm.judge)
	);

	// bus outputs; data stays driven until the strobes are released
	assign data_out = dout_r;
	assign data_oe  = rd_cyc_r & ~in_idle & rd_req;
	// with mproc low the host expects no wait handshake, so ready_b stays high
	assign ready_b  = ~(mproc & in_done);

	// results
	assign result_code = sm.code;
	assign sync_go     = sm.sync_go;
	assign sw_run      = run_r;
	assign sw_event    = sw_event_r;
	assign ext_error   = ext_err_r;
endmodule

/* bench/time_mgmt_regs_assertions.sv */
// port-level assertions for the time management register block
// bound to time_mgmt_regs from the bench top; mproc is expected high
`timescale 1ns/1ps
`include "time_mgmt_consts.svh"
module time_mgmt_regs_assertions
	import time_mgmt_pkg::*;
(
	// clock and reset
	input wire logic                  clk_sys,
	input wire logic                  rst_b,
	// bus
	input wire logic                  cs_b,
	input wire logic                  rd_b,
	input wire logic [`TM_ADDR_W-1:0] addr,
	input wire logic [`TM_DATA_W-1:0] data_out,
	input wire logic                  data_oe,
	input wire logic                  ready_b,
	input wire logic                  mproc,
	// marker evaluation
	input wire logic                  marker,
	input wire logic                  msg_err,
	input wire logic                  marker_to,
	input wire logic                  mismatch,
	input wire logic                  warn,
	input wire logic                  go_reached,
	input wire logic [1:0]            op_mode,
	// pins and results
	input wire logic                  swevent,
	input wire logic                  exterin,
	input wire logic [1:0]            result_code,
	input wire logic                  sync_go,
	input wire logic                  sw_event,
	input wire logic                  ext_error
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// timeout only counts outside stand-alone operation
	wire alone = op_mode == 2'h2;
	wire fatal = msg_err | (marker_to & ~alone);
	wire clean = marker & ~fatal & ~ext_error;
	sequence rd_take;
		$fell(rd_b) && !cs_b;
	endsequence
	sequence rdy_seq;
		ready_b ##1 !ready_b;
	endsequence
	AST_CODE_OK: assert property (clean && !mismatch && !(alone && warn) |=> result_code == 2'h0 && sync_go)
		else $error("clean marker did not give code 00 with sync");
	AST_CODE_MSG: assert property (marker && fatal |=> result_code == 2'h1 && !sync_go)
		else $error("message error did not give code 01");
	AST_CODE_EXT: assert property (marker && !fatal && ext_error |=> result_code == 2'h2 && !sync_go)
		else $error("external error did not block sync");
	AST_CODE_GO: assert property (clean && mismatch && go_reached && !alone |=> result_code == 2'h3 && sync_go)
		else $error("go threshold did not force sync");
	AST_CODE_WARN: assert property (clean && !mismatch && warn && alone |=> result_code == 2'h2 && sync_go)
		else $error("stand-alone warning did not give code 10 with sync");
	AST_NO_GO: assert property (!marker |=> !sync_go)
		else $error("sync without a marker");
	AST_EXT_PIN: assert property (exterin |=> ext_error)
		else $error("external error pin not followed");
	AST_EVT_PIN: assert property (swevent |=> sw_event)
		else $error("event pin gave no stopwatch event");
	AST_CTRL_ZERO: assert property (rd_take ##0 addr == `TM_CTRL_ADDR |=> data_out[15:10] == 6'h00)
		else $error("unused control bits not zero");
	AST_RD_READY: assert property (rd_take ##0 mproc |=> rdy_seq)
		else $error("read not completed by ready");
	AST_OE_READ: assert property (rd_take |=> data_oe)
		else $error("read data not driven after the take");
	AST_OE_FREE: assert property (rd_b || cs_b |-> !data_oe)
		else $error("data driven without a read strobe");
endmodule

/* bench/mproc_host.sv */
// microprocessor model driving the parallel register pins
// assumes mproc=1 so each access ends with ready_b low
`timescale 1ns/1ps
module mproc_host (
	// clock
	input  wire logic        clk_sys,
	// register pins
	output logic             cs_b,
	output logic             rd_b,
	output logic             wr_b,
	output logic [4:0]       addr,
	output logic [15:0]      data_in,
	input  wire logic [15:0] data_out,
	input  wire logic        ready_b
);
	initial begin
		cs_b = 1'b1;
		rd_b = 1'b1;
		wr_b = 1'b1;
		addr = 5'h00;
		data_in = 16'h0000;
	end
	// one access; ok stays low when ready never comes
	task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q,
		output logic ok);
		q  = 16'h0000;
		ok = 1'b0;
		@(posedge clk_sys);
		cs_b <= 1'b0;
		rd_b <= w;
		wr_b <= !w;
		addr <= a;
		if (w)
			data_in <= d;
		// ready_b and data_out are looked at while settled, before the edge that samples them
		for (int i = 0; i < 20; i++) begin
			@(negedge clk_sys);
			if (ready_b === 1'b0) begin
				q  = data_out;
				ok = 1'b1;
				break;
			end
		end
		@(posedge clk_sys);
		cs_b <= 1'b1;
		rd_b <= 1'b1;
		wr_b <= 1'b1;
		// released bus must not look like held data
		data_in <= ~data_in;
		@(posedge clk_sys);
	endtask
endmodule

/* bench/tb_time_mgmt_regs.sv */
// self-checking bench for the time management register block
// assumes one 100 MHz clock; bus cycles come from the host model
`timescale 1ns/1ps
`include "time_mgmt_consts.svh"
module tb_time_mgmt_regs
	import time_mgmt_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        rst_b   = 1'b0;
	logic        mproc   = 1'b1;
	logic        msg_valid = 1'b0;
	logic        marker  = 1'b0;
	logic        tvld    = 1'b1;
	logic        pfgwave = 1'b0;
	logic        swstart = 1'b0;
	logic        swevent = 1'b0;
	logic        exterin = 1'b0;
	logic [14:0] flg     = 15'h0000;
	logic [6:0]  cnd     = 7'h00;
	logic        cs_b, rd_b, wr_b, ready_b, sync_go, sw_run, sw_event, ext_error;
	logic [4:0]  addr;
	logic [15:0] data_in, data_out;
	logic [1:0]  result_code;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          evs = 0;

	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (sw_event === 1'b1) evs <= evs + 1;

	mproc_host host (.clk_sys, .cs_b, .rd_b, .wr_b, .addr, .data_in, .data_out, .ready_b);
	time_mgmt_regs dut (.clk_sys, .rst_b, .cs_b, .rd_b, .wr_b, .addr, .data_in, .data_out, .data_oe(),
		.ready_b, .mproc, .msg_valid, .msg_pulse(flg[14]), .msg_wave(flg[13]), .msg_init(flg[12]),
		.msg_chain(flg[11:8]), .msg_mission(flg[7:0]), .marker, .msg_err(cnd[4]), .marker_to(cnd[3]),
		.mismatch(cnd[2]), .warn(cnd[1]), .go_reached(cnd[0]), .op_mode(cnd[6:5]), .tvld, .pfgwave,
		.swstart, .swevent, .exterin, .result_code, .sync_go, .sw_run, .sw_event, .ext_error);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] d);
		logic [15:0] q;
		logic        ok;
		host.xfer(1'b1, `TM_CTRL_ADDR, d, q, ok);
		if (!ok) begin
			miscompares++;
			wrap_up;
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] q;
		logic        ok;
		host.xfer(1'b0, a, 16'h0000, q, ok);
		if (!ok) begin
			miscompares++;
			wrap_up;
		end else
			check(q, exp);
	endtask
	// c = {op_mode, msg_err, marker_to, mismatch, warn, go_reached}
	task automatic mark(input logic [6:0] c, input logic [2:0] exp);
		@(posedge clk_sys);
		cnd <= c;
		marker <= 1'b1;
		@(posedge clk_sys);
		marker <= 1'b0;
		@(negedge clk_sys);
		check({result_code, sync_go}, exp);
	endtask
	task automatic msg(input logic [14:0] f);
		@(posedge clk_sys);
		flg <= f;
		msg_valid <= 1'b1;
		@(posedge clk_sys);
		msg_valid <= 1'b0;
		// flags outside the pulse must not be captured
		flg <= ~f;
	endtask

	task automatic s_reset;
		rd(`TM_CTRL_ADDR, 16'h0200);
		rd(`TM_MSTAT_ADDR, 16'h0000);
	endtask
	task automatic s_status;
		msg(15'h1234);
		mark(7'h04, 3'h7);
		rd(`TM_MSTAT_ADDR, 16'h9234);
		msg(15'h7fff);
		msg(15'h4bcd);
		mark(7'h00, 3'h1);
		rd(`TM_MSTAT_ADDR, 16'h4bcd);
		mark(7'h00, 3'h1);
		rd(`TM_MSTAT_ADDR, 16'h4bcd);
	endtask
	task automatic s_ctrl;
		pfgwave <= 1'b1;
		wr(16'hffbf);
		rd(`TM_CTRL_ADDR, 16'h0230);
		check(ext_error, 1'b1);
		mark(7'h00, 3'h4);
		@(posedge clk_sys);
		swevent <= 1'b1;
		@(posedge clk_sys);
		swevent <= 1'b0;
		rd(`TM_CTRL_ADDR, 16'h0230);
		check(evs, 1);
		wr(16'h00c0);
		rd(`TM_CTRL_ADDR, 16'h02d0);
		check(evs, 2);
		wr(16'h01c0);
		rd(`TM_CTRL_ADDR, 16'h03d0);
		check(sw_run, 1'b1);
		wr(16'h00c0);
		check(sw_run, 1'b0);
		check(evs, 2);
		swstart <= 1'b1;
		wr(16'h0040);
		rd(`TM_CTRL_ADDR, 16'h0350);
		check(sw_run, 1'b1);
		exterin <= 1'b1;
		mark(7'h00, 3'h4);
		exterin <= 1'b0;
	endtask
	task automatic s_codes;
		logic [9:0] tbl [8];
		tbl = '{10'h001, 10'h082, 10'h142, 10'h241, 10'h024, 10'h12f, 10'h22c, 10'h215};
		for (int i = 0; i < 8; i++)
			mark(tbl[i][9:3], tbl[i][2:0]);
	endtask
	// select set before a mid-run reset must come back cleared
	task automatic s_rereset;
		wr(16'h00c0);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(`TM_CTRL_ADDR, 16'h0310);
		rd(`TM_MSTAT_ADDR, 16'h0000);
	endtask
	task automatic wrap_up;
		if (miscompares == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		s_reset;
		s_status;
		s_ctrl;
		s_codes;
		s_rereset;
		wrap_up;
	end
endmodule

bind time_mgmt_regs time_mgmt_regs_assertions chk (.clk_sys, .rst_b, .cs_b, .rd_b, .addr, .data_out, .data_oe, .ready_b,
	.mproc, .marker, .msg_err, .marker_to, .mismatch, .warn, .go_reached, .op_mode, .swevent, .exterin,
	.result_code, .sync_go, .sw_event, .ext_error);
